// File: logic/hpsc_event_flag.sv
`timescale 1ns/10ps
// ==========================================================================
// sticky event flag, hardware set wins over software clear
// ==========================================================================
module hpsc_event_flag (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // set pulse from a slot pin or core side status event, clear from a write of one
  input wire logic setEvt,
  input wire logic clrEvt,
  output logic flag_ff
);

  // an event landing in the clearing cycle must not be lost
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      flag_ff <= 1'b0;
    end else if (setEvt) begin
      flag_ff <= 1'b1;
    end else if (clrEvt) begin
      flag_ff <= 1'b0;
    end
  end

endmodule

// File: logic/hpsc_pkg.sv
// ==========================================================================
// constants shared by the slot control / status register block
// ==========================================================================
package hpsc_pkg;

  // ========================================================================
  // configuration space byte offsets
  // ========================================================================
  localparam logic [11:0] HPSC_SLOT_OFS = 12'h0F8; // control low half, status high half
  localparam logic [11:0] HPSC_AER_OFS = 12'h100;  // error reporting extended header

  // ========================================================================
  // slot control field positions
  // ========================================================================
  localparam int HPSC_CTL_ABP_EN = 0;
  localparam int HPSC_CTL_PFD_EN = 1;
  localparam int HPSC_CTL_PDC_EN = 3;
  localparam int HPSC_CTL_CC_EN = 4;
  localparam int HPSC_CTL_HPI_EN = 5;
  localparam int HPSC_CTL_ATTN_LSB = 6;
  localparam int HPSC_CTL_PWRI_LSB = 8;
  localparam int HPSC_CTL_PWRC = 10;
  localparam int HPSC_CTL_DLL_EN = 12;

  // control reset value: both indicators off, everything else zero
  localparam logic [15:0] HPSC_CTL_RST = 16'h03C0;
  // bits that software may write; 2, 11 and 15:13 are reserved
  localparam logic [15:0] HPSC_CTL_WMASK = 16'h17FB;

  // ========================================================================
  // slot status field positions (within the 32-bit word)
  // ========================================================================
  localparam int HPSC_ST_ABP = 16;
  localparam int HPSC_ST_PFD = 17;
  localparam int HPSC_ST_LCHG = 18;
  localparam int HPSC_ST_PDC = 19;
  localparam int HPSC_ST_CC = 20;
  localparam int HPSC_ST_LATCH = 21;
  localparam int HPSC_ST_PRES = 22;
  localparam int HPSC_ST_DLL = 24;

  // ========================================================================
  // event flag indices (write-one-to-clear group)
  // ========================================================================
  localparam int HPSC_FLG_ABP = 0;
  localparam int HPSC_FLG_PFD = 1;
  localparam int HPSC_FLG_PDC = 2;
  localparam int HPSC_FLG_CC = 3;
  localparam int HPSC_FLG_DLL = 4;
  localparam int HPSC_FLG_N = 5;
  localparam int HPSC_WAKE_N = 3; // abp, pfd and pdc may also wake

  // ========================================================================
  // indicator encodings
  // ========================================================================
  localparam logic [1:0] HPSC_IND_RSVD = 2'h0;
  localparam logic [1:0] HPSC_IND_ON = 2'h1;
  localparam logic [1:0] HPSC_IND_BLINK = 2'h2;
  localparam logic [1:0] HPSC_IND_OFF = 2'h3;

  // ========================================================================
  // error reporting extended capability header
  // ========================================================================
  localparam logic [15:0] HPSC_AER_ID = 16'h0001;
  localparam logic [3:0] HPSC_AER_VER = 4'h1;
  localparam logic [11:0] HPSC_NEXT_UP = 12'h140;
  localparam logic [11:0] HPSC_NEXT_DN = 12'h20C;

  // ========================================================================
  // reset values of synchronised slot pins: {card present, latch, fault, button}
  // ========================================================================
  localparam logic [3:0] HPSC_PIN_RST = 4'h8;

endpackage

// File: logic/hpsc_slot_regs.sv
`timescale 1ns/10ps
module hpsc_slot_regs #(
  parameter bit SLOT_IMPL = 1'b1,
  parameter bit LINK_REPORT = 1'b1,
  parameter bit DOWNSTREAM = 1'b1
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // configuration space access
  input wire logic [11:0] cfgAddr,
  input wire logic cfgWrEn,
  input wire logic cfgRdEn,
  input wire logic [3:0] cfgByteEn,
  input wire logic [31:0] cfgWrData,
  output logic [31:0] cfgRdData,
  output logic cfgRdValid,
  // slot pins, asynchronous
  input wire logic attnButton,
  input wire logic powerFault,
  input wire logic latchOpen,
  input wire logic cardPresent,
  // core side status, same clock
  input wire logic cmdDone,
  input wire logic linkActive,
  // slot controls
  output logic [1:0] attnIndicator,
  output logic [1:0] powerIndicator,
  output logic slotPowerOff,
  // indicator messages
  output logic attnMsgValid,
  output logic [1:0] attnMsgCode,
  output logic pwrMsgValid,
  output logic [1:0] pwrMsgCode,
  // notification
  output logic hotplugIrq,
  output logic wakeEvent
);
  import hpsc_pkg::*;

  // ========================================================================
  // declarations
  // ========================================================================
  logic [3:0] pinSync;
  logic btnPrev_ff;
  logic faultPrev_ff;
  logic latchState_ff;
  logic presState_ff;
  logic linkPrev_ff;
  logic latchChg_ff;
  logic [15:0] ctrl_ff;
  logic [15:0] nxt_ctrl;
  logic [HPSC_FLG_N-1:0] flagSet;
  logic [HPSC_FLG_N-1:0] flagClr;
  logic [HPSC_FLG_N-1:0] flags;
  logic [HPSC_FLG_N-1:0] flagEn;
  logic slotHit;
  logic aerHit;
  logic slotWr;
  logic btnPress;
  logic faultDet;
  logic presChg;
  logic latchChg;
  logic linkChg;
  logic presBit;
  logic [31:0] slotWord;
  logic [31:0] aerWord;
  logic [31:0] nxt_rdData;
  logic [11:0] nextPtr;
  logic attnMsg_ff;
  logic [1:0] attnCode_ff;
  logic pwrMsg_ff;
  logic [1:0] pwrCode_ff;
  logic irq_ff;
  logic wake_ff;
  logic [31:0] rdData_ff;
  logic rdValid_ff;

  // ========================================================================
  // slot pin synchronisation and edge detection
  // ========================================================================
  // pins are bounce-free by assumption; no debounce is done here
  hpsc_sync #(
    .WIDTH(4),
    .RST_VAL(HPSC_PIN_RST)
  ) u_pinSync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .asyncIn({cardPresent, latchOpen, powerFault, attnButton}),
    .syncOut(pinSync)
  );

  // previous samples; presence starts at one so an occupied slot gives no event
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      btnPrev_ff <= 1'b0;
      faultPrev_ff <= 1'b0;
      latchState_ff <= 1'b0;
      presState_ff <= 1'b1;
      linkPrev_ff <= 1'b0;
    end else begin
      btnPrev_ff <= pinSync[0];
      faultPrev_ff <= pinSync[1];
      latchState_ff <= pinSync[2];
      presState_ff <= pinSync[3];
      linkPrev_ff <= linkActive;
    end
  end

  // events: rising press and fault, any change of latch, presence, link
  assign btnPress = pinSync[0] & ~btnPrev_ff;
  assign faultDet = pinSync[1] & ~faultPrev_ff;
  assign latchChg = pinSync[2] ^ latchState_ff;
  assign presChg = SLOT_IMPL & (pinSync[3] ^ presState_ff);
  assign linkChg = linkActive ^ linkPrev_ff;
  // without a slot the presence bit is pinned high
  assign presBit = SLOT_IMPL ? presState_ff : 1'b1;

  // ========================================================================
  // configuration access decode
  // ========================================================================
  always_comb begin
    slotHit = 1'b0;
    aerHit = 1'b0;
    if (cfgAddr[11:2] == HPSC_SLOT_OFS[11:2]) begin
      slotHit = 1'b1;
    end else if (cfgAddr[11:2] == HPSC_AER_OFS[11:2]) begin
      aerHit = 1'b1;
    end
  end
  assign slotWr = cfgWrEn & slotHit;

  // ========================================================================
  // slot control register
  // ========================================================================
  // byte-wise merge; reserved bits stay zero whatever is written
  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (slotWr && cfgByteEn[0]) begin
      nxt_ctrl[7:0] = cfgWrData[7:0] & HPSC_CTL_WMASK[7:0];
    end
    if (slotWr && cfgByteEn[1]) begin
      nxt_ctrl[15:8] = cfgWrData[15:8] & HPSC_CTL_WMASK[15:8];
    end
  end

  // enables, indicators and power control all reset from one constant
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ctrl_ff <= HPSC_CTL_RST;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  assign attnIndicator = ctrl_ff[HPSC_CTL_ATTN_LSB +: 2];
  assign powerIndicator = ctrl_ff[HPSC_CTL_PWRI_LSB +: 2];
  assign slotPowerOff = ctrl_ff[HPSC_CTL_PWRC];

  // ========================================================================
  // indicator messages
  // ========================================================================
  // every write to the field sends a message, even if the value is unchanged
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      attnMsg_ff <= 1'b0;
      attnCode_ff <= HPSC_IND_OFF;
      pwrMsg_ff <= 1'b0;
      pwrCode_ff <= HPSC_IND_OFF;
    end else begin
      attnMsg_ff <= slotWr & cfgByteEn[0];
      pwrMsg_ff <= slotWr & cfgByteEn[1];
      if (slotWr && cfgByteEn[0]) begin
        attnCode_ff <= cfgWrData[HPSC_CTL_ATTN_LSB +: 2];
      end
      if (slotWr && cfgByteEn[1]) begin
        pwrCode_ff <= cfgWrData[HPSC_CTL_PWRI_LSB +: 2];
      end
    end
  end

  assign attnMsgValid = attnMsg_ff;
  assign attnMsgCode = attnCode_ff;
  assign pwrMsgValid = pwrMsg_ff;
  assign pwrMsgCode = pwrCode_ff;

  // ========================================================================
  // slot status event flags
  // ========================================================================
  assign flagSet[HPSC_FLG_ABP] = btnPress;
  assign flagSet[HPSC_FLG_PFD] = faultDet;
  assign flagSet[HPSC_FLG_PDC] = presChg;
  assign flagSet[HPSC_FLG_CC] = cmdDone;
  assign flagSet[HPSC_FLG_DLL] = LINK_REPORT & linkChg;

  // write one to clear; status half sits in byte lanes 2 and 3
  assign flagClr[HPSC_FLG_ABP] = slotWr & cfgByteEn[2] & cfgWrData[HPSC_ST_ABP];
  assign flagClr[HPSC_FLG_PFD] = slotWr & cfgByteEn[2] & cfgWrData[HPSC_ST_PFD];
  assign flagClr[HPSC_FLG_PDC] = slotWr & cfgByteEn[2] & cfgWrData[HPSC_ST_PDC];
  assign flagClr[HPSC_FLG_CC] = slotWr & cfgByteEn[2] & cfgWrData[HPSC_ST_CC];
  assign flagClr[HPSC_FLG_DLL] = slotWr & cfgByteEn[3] & cfgWrData[HPSC_ST_DLL];

  genvar gf;
  generate
    for (gf = 0; gf < HPSC_FLG_N; gf++) begin : g_flag
      hpsc_event_flag u_flag (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .setEvt(flagSet[gf]),
        .clrEvt(flagClr[gf]),
        .flag_ff(flags[gf])
      );
    end
  endgenerate

  // latch change is read-only: it holds until reset, software cannot clear it
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      latchChg_ff <= 1'b0;
    end else if (latchChg) begin
      latchChg_ff <= 1'b1;
    end
  end

  // ========================================================================
  // interrupt and wake generation
  // ========================================================================
  // link change enable only counts where link reporting exists
  assign flagEn[HPSC_FLG_ABP] = ctrl_ff[HPSC_CTL_ABP_EN];
  assign flagEn[HPSC_FLG_PFD] = ctrl_ff[HPSC_CTL_PFD_EN];
  assign flagEn[HPSC_FLG_PDC] = ctrl_ff[HPSC_CTL_PDC_EN];
  assign flagEn[HPSC_FLG_CC] = ctrl_ff[HPSC_CTL_CC_EN];
  assign flagEn[HPSC_FLG_DLL] = LINK_REPORT & ctrl_ff[HPSC_CTL_DLL_EN];

  // level interrupt; wake ignores the master enable since it serves low power
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      irq_ff <= 1'b0;
      wake_ff <= 1'b0;
    end else begin
      irq_ff <= ctrl_ff[HPSC_CTL_HPI_EN] & (|(flags & flagEn));
      wake_ff <= |(flags[HPSC_WAKE_N-1:0] & flagEn[HPSC_WAKE_N-1:0]);
    end
  end

  assign hotplugIrq = irq_ff;
  assign wakeEvent = wake_ff;

  // ========================================================================
  // read path
  // ========================================================================
  assign nextPtr = DOWNSTREAM ? HPSC_NEXT_DN : HPSC_NEXT_UP;

  // reserved positions are tied to zero
  always_comb begin
    slotWord = 32'h0000_0000;
    slotWord[15:0] = ctrl_ff;
    slotWord[HPSC_ST_ABP] = flags[HPSC_FLG_ABP];
    slotWord[HPSC_ST_PFD] = flags[HPSC_FLG_PFD];
    slotWord[HPSC_ST_LCHG] = latchChg_ff;
    slotWord[HPSC_ST_PDC] = flags[HPSC_FLG_PDC];
    slotWord[HPSC_ST_CC] = flags[HPSC_FLG_CC];
    slotWord[HPSC_ST_LATCH] = latchState_ff;
    slotWord[HPSC_ST_PRES] = presBit;
    slotWord[HPSC_ST_DLL] = flags[HPSC_FLG_DLL];
  end

  assign aerWord = {nextPtr, HPSC_AER_VER, HPSC_AER_ID};

  // unmapped offsets read as zero
  always_comb begin
    if (slotHit) begin
      nxt_rdData = slotWord;
    end else if (aerHit) begin
      nxt_rdData = aerWord;
    end else begin
      nxt_rdData = 32'h0000_0000;
    end
  end

  // one-cycle read answer
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rdData_ff <= 32'h0000_0000;
      rdValid_ff <= 1'b0;
    end else begin
      rdValid_ff <= cfgRdEn;
      if (cfgRdEn) begin
        rdData_ff <= nxt_rdData;
      end
    end
  end

  assign cfgRdData = rdData_ff;
  assign cfgRdValid = rdValid_ff;

  // ========================================================================
  // assertions
  // ========================================================================
  sequence s_ctrlLowWrite;
    cfgWrEn && cfgAddr[11:2] == HPSC_SLOT_OFS[11:2] && cfgByteEn[0];
  endsequence

  sequence s_ctrlHighWrite;
    cfgWrEn && cfgAddr[11:2] == HPSC_SLOT_OFS[11:2] && cfgByteEn[1];
  endsequence

  property p_pressSetsFlag;
    @(posedge clk_sys) disable iff (sys_rst)
      $rose(pinSync[0]) |=> flags[HPSC_FLG_ABP];
  endproperty
  a_pressSetsFlag: assert property (p_pressSetsFlag)
    else $error("button press did not set its flag");

  property p_faultSetsFlag;
    @(posedge clk_sys) disable iff (sys_rst)
      (pinSync[1] && !faultPrev_ff) |=> slotWord[HPSC_ST_PFD];
  endproperty
  a_faultSetsFlag: assert property (p_faultSetsFlag)
    else $error("power fault did not set its flag");

  property p_clearPresFlag;
    @(posedge clk_sys) disable iff (sys_rst)
      (slotWr && cfgByteEn[2] && cfgWrData[HPSC_ST_PDC] && !presChg) |=> !flags[HPSC_FLG_PDC];
  endproperty
  a_clearPresFlag: assert property (p_clearPresFlag)
    else $error("write of one left presence change flag set");

  property p_masterGate;
    @(posedge clk_sys) disable iff (sys_rst)
      !ctrl_ff[HPSC_CTL_HPI_EN] |=> !hotplugIrq;
  endproperty
  a_masterGate: assert property (p_masterGate)
    else $error("interrupt raised with master enable off");

  property p_cmdIrq;
    @(posedge clk_sys) disable iff (sys_rst)
      (ctrl_ff[HPSC_CTL_HPI_EN] && ctrl_ff[HPSC_CTL_CC_EN] && flags[HPSC_FLG_CC]) |=> hotplugIrq;
  endproperty
  a_cmdIrq: assert property (p_cmdIrq)
    else $error("enabled command completion gave no interrupt");

  property p_attnMsg;
    @(posedge clk_sys) disable iff (sys_rst)
      s_ctrlLowWrite |=> attnMsgValid && attnMsgCode == $past(cfgWrData[7:6])
        && attnIndicator == attnMsgCode;
  endproperty
  a_attnMsg: assert property (p_attnMsg)
    else $error("attention write sent no matching message");

  property p_pwrMsg;
    @(posedge clk_sys) disable iff (sys_rst)
      s_ctrlHighWrite |=> pwrMsgValid && pwrMsgCode == $past(cfgWrData[9:8])
        && slotPowerOff == $past(cfgWrData[10]);
  endproperty
  a_pwrMsg: assert property (p_pwrMsg)
    else $error("power indicator or control write not honoured");

  property p_linkChange;
    @(posedge clk_sys) disable iff (sys_rst)
      (LINK_REPORT && linkActive != linkPrev_ff) |=> flags[HPSC_FLG_DLL];
  endproperty
  a_linkChange: assert property (p_linkChange)
    else $error("link active change not flagged");

  property p_capHeader;
    @(posedge clk_sys) disable iff (sys_rst)
      (cfgRdEn && cfgAddr[11:2] == HPSC_AER_OFS[11:2]) |=> cfgRdValid
        && cfgRdData[19:0] == 20'h10001 && cfgRdData[31:20] == nextPtr;
  endproperty
  a_capHeader: assert property (p_capHeader)
    else $error("extended header read returned wrong value");

  property p_noSlotPresence;
    @(posedge clk_sys) disable iff (sys_rst)
      (!SLOT_IMPL && cfgRdEn && slotHit) |=> cfgRdData[HPSC_ST_PRES];
  endproperty
  a_noSlotPresence: assert property (p_noSlotPresence)
    else $error("presence bit low with no slot");

endmodule

// File: logic/hpsc_sync.sv
`timescale 1ns/10ps
// ==========================================================================
// two-flop synchroniser, one chain per bit
// ==========================================================================
module hpsc_sync #(
  parameter int WIDTH = 4,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // asynchronous levels in, synchronised levels out
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      logic meta_ff;
      logic sync_ff;
      // first stage is read only by the second
      always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
          meta_ff <= RST_VAL[gi];
          sync_ff <= RST_VAL[gi];
        end else begin
          meta_ff <= asyncIn[gi];
          sync_ff <= meta_ff;
        end
      end
      assign syncOut[gi] = sync_ff;
    end
  endgenerate

endmodule

// File: sim/hpsc_slot_model.sv
`timescale 1ns/10ps
// ==========================================================================
// slot side model: button, fault, latch, presence, command done, link state
// ==========================================================================
module hpsc_slot_model (
  // clock
  input wire logic clk_sys,
  // slot pins
  output logic attnButton,
  output logic powerFault,
  output logic latchOpen,
  output logic cardPresent,
  // core side status
  output logic cmdDone,
  output logic linkActive
);
  logic [5:0] pinVec = 6'h08; // card fitted at power up
  // one vector keeps every level in one place
  assign {linkActive, cmdDone, cardPresent, latchOpen, powerFault, attnButton} = pinVec;
  // levels move only on the falling edge, clear of the sampling edge
  task automatic setPin(input int idx, input logic lvl);
    @(negedge clk_sys);
    pinVec[idx] = lvl;
  endtask
  // slot pins need several cycles, or the synchroniser may miss them
  task automatic pulse(input int idx, input int len);
    setPin(idx, 1'b1);
    repeat (len - 1) @(negedge clk_sys);
    setPin(idx, 1'b0);
  endtask
endmodule

// File: sim/hpsc_slot_regs_tb.sv
`timescale 1ns/10ps
// ==========================================================================
// register bench for the slot control and status block
// ==========================================================================
module hpsc_slot_regs_tb;
  import hpsc_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [11:0] cfgAddr = 12'h000;
  logic cfgWrEn = 1'b0;
  logic cfgRdEn = 1'b0;
  logic [3:0] cfgByteEn = 4'h0;
  logic [31:0] cfgWrData = 32'h0;
  logic [31:0] cfgRdData;
  logic [31:0] upRdData;
  logic cfgRdValid, attnButton, powerFault, latchOpen, cardPresent;
  logic cmdDone, linkActive, slotPowerOff, attnMsgValid, pwrMsgValid;
  logic hotplugIrq, wakeEvent;
  logic [1:0] attnIndicator, powerIndicator, attnMsgCode, pwrMsgCode;
  int n_mismatch = 0;
  int check_count = 0;
  int cycCount = 0;

  // ========================================================================
  // clock, design and slot model
  // ========================================================================
  always #25 clk_sys = ~clk_sys;
  hpsc_slot_regs dut (.clk_sys, .sys_rst, .cfgAddr, .cfgWrEn, .cfgRdEn,
    .cfgByteEn, .cfgWrData, .cfgRdData, .cfgRdValid, .attnButton, .powerFault,
    .latchOpen, .cardPresent, .cmdDone, .linkActive, .attnIndicator,
    .powerIndicator, .slotPowerOff, .attnMsgValid, .attnMsgCode, .pwrMsgValid,
    .pwrMsgCode, .hotplugIrq, .wakeEvent);
  // second copy on the same bus: no slot, no link reporting, upstream pointer
  hpsc_slot_regs #(.SLOT_IMPL(1'b0), .LINK_REPORT(1'b0), .DOWNSTREAM(1'b0)) dutUp (
    .clk_sys, .sys_rst, .cfgAddr, .cfgWrEn, .cfgRdEn, .cfgByteEn, .cfgWrData,
    .cfgRdData(upRdData), .cfgRdValid(), .attnButton, .powerFault, .latchOpen,
    .cardPresent, .cmdDone, .linkActive, .attnIndicator(), .powerIndicator(),
    .slotPowerOff(), .attnMsgValid(), .attnMsgCode(), .pwrMsgValid(), .pwrMsgCode(),
    .hotplugIrq(), .wakeEvent());
  hpsc_slot_model slot (.clk_sys, .attnButton, .powerFault, .latchOpen,
    .cardPresent, .cmdDone, .linkActive);

  // ========================================================================
  // access and compare tasks
  // ========================================================================
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // strobe is one cycle wide, so it drops on the next falling edge
  task automatic wr(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
    @(negedge clk_sys);
    cfgAddr = a;
    cfgByteEn = be;
    cfgWrData = d;
    cfgWrEn = 1'b1;
    @(negedge clk_sys);
    cfgWrEn = 1'b0;
  endtask
  // valid stands a single cycle, so it is sampled right after the take edge
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input string nm);
    @(negedge clk_sys);
    cfgAddr = a;
    cfgRdEn = 1'b1;
    @(negedge clk_sys);
    cfgRdEn = 1'b0;
    chk({nm, " valid"}, cfgRdValid, 1'b1);
    chk(nm, cfgRdData, e);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // hang guard, far above the hundred or so cycles the tests need
  always @(posedge clk_sys) begin
    cycCount++;
    if (cycCount >= 3000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  // ========================================================================
  // tests
  // ========================================================================
  initial begin
    tick(5);
    sys_rst = 1'b0;
    rdchk(HPSC_SLOT_OFS, 32'h0040_03C0, "slot reset");
    rdchk(HPSC_AER_OFS, 32'h20C1_0001, "aer header");
    chk("aer up", upRdData, 32'h1401_0001);
    rdchk(12'h104, 32'h0, "unmapped");
    chk("pins reset", {attnIndicator, powerIndicator, slotPowerOff}, 5'h1E);
    $display("test reset done");
    wr(HPSC_SLOT_OFS, 4'h3, 32'hFFFF_FFFF);
    chk("msg all", {attnMsgValid, pwrMsgValid}, 2'h3);
    rdchk(HPSC_SLOT_OFS, 32'h0040_17FB, "ctrl mask");
    chk("pins all", {attnIndicator, powerIndicator, slotPowerOff}, 5'h1F);
    wr(HPSC_SLOT_OFS, 4'h3, 32'h0000_0155);
    chk("msg on", {attnMsgValid, attnMsgCode, pwrMsgValid, pwrMsgCode}, 6'h2D);
    tick(1);
    chk("msg end", {attnMsgValid, pwrMsgValid}, 2'h0);
    chk("pins on", {attnIndicator, powerIndicator, slotPowerOff}, 5'h0A);
    wr(HPSC_SLOT_OFS, 4'h1, 32'h0000_0080);
    chk("lane0 msg", {attnMsgValid, attnMsgCode, pwrMsgValid}, 4'hC);
    wr(HPSC_AER_OFS, 4'hF, 32'h0);
    rdchk(HPSC_AER_OFS, 32'h20C1_0001, "aer ro");
    $display("test control done");
    wr(HPSC_SLOT_OFS, 4'h3, 32'h0000_0021);
    slot.pulse(0, 4);
    tick(2);
    rdchk(HPSC_SLOT_OFS, 32'h0041_0021, "button");
    chk("irq wake", {hotplugIrq, wakeEvent}, 2'h3);
    wr(HPSC_SLOT_OFS, 4'h4, 32'h0001_0000);
    tick(2);
    rdchk(HPSC_SLOT_OFS, 32'h0040_0021, "button clr");
    chk("irq off", {hotplugIrq, wakeEvent}, 2'h0);
    wr(HPSC_SLOT_OFS, 4'h3, 32'h0000_0001);
    slot.pulse(0, 4);
    tick(2);
    chk("no master", {hotplugIrq, wakeEvent}, 2'h1);
    wr(HPSC_SLOT_OFS, 4'h4, 32'h0001_0000);
    $display("test button done");
    wr(HPSC_SLOT_OFS, 4'h3, 32'h0000_0032);
    slot.pulse(1, 4);
    slot.pulse(4, 1);
    tick(3);
    rdchk(HPSC_SLOT_OFS, 32'h0052_0032, "fault cmd");
    chk("fault irq", {hotplugIrq, wakeEvent}, 2'h3);
    wr(HPSC_SLOT_OFS, 4'h4, 32'h0012_0000);
    tick(2);
    rdchk(HPSC_SLOT_OFS, 32'h0040_0032, "fault clr");
    chk("fault off", {hotplugIrq, wakeEvent}, 2'h0);
    $display("test fault done");
    wr(HPSC_SLOT_OFS, 4'h3, 32'h0000_1028);
    slot.setPin(2, 1'b1);
    tick(6);
    wr(HPSC_SLOT_OFS, 4'h4, 32'h0004_0000);
    rdchk(HPSC_SLOT_OFS, 32'h0064_1028, "latch");
    chk("latch irq", hotplugIrq, 1'b0);
    slot.setPin(3, 1'b0);
    slot.setPin(5, 1'b1);
    tick(6);
    rdchk(HPSC_SLOT_OFS, 32'h012C_1028, "pres link");
    chk("no slot", upRdData, 32'h0064_1028);
    chk("pres irq", {hotplugIrq, wakeEvent}, 2'h3);
    wr(HPSC_SLOT_OFS, 4'hC, 32'h0108_0000);
    tick(2);
    rdchk(HPSC_SLOT_OFS, 32'h0024_1028, "pres clr");
    chk("pres off", hotplugIrq, 1'b0);
    $display("test sensors done");
    give_verdict();
  end
endmodule
